// ==== tbd_map.vh ====
// register offsets, field widths and build defaults of the discovery bank
`ifndef TBD_MAP_VH
`define TBD_MAP_VH
`define TBD_OFS_DIRECT_IDX   16'h8E50
`define TBD_OFS_TLB_PARTS    16'h8E54
`define TBD_OFS_OG_WIDTH     16'h8E58
`define TBD_OFS_PARTID_WIDTH 16'h8E5C
`define TBD_OFS_HZRD_ENTRIES 16'h8E60
`define TBD_OFS_SLOTRAM_TYPE 16'h8E64
`define TBD_OFS_CACHERAM_TYPE 16'h8E68
`define TBD_W_DIRECT_IDX     1
`define TBD_W_TLB_PARTS      5
`define TBD_W_OG_WIDTH       6
`define TBD_W_PARTID_WIDTH   4
`define TBD_W_HZRD_ENTRIES   7
`define TBD_W_SLOTRAM_TYPE   2
`define TBD_W_CACHERAM_TYPE  2
`define TBD_DEF_DIRECT_IDX   1'b1
`define TBD_DEF_TLB_PARTS    5'h10
`define TBD_DEF_OG_WIDTH     6'h20
`define TBD_DEF_PARTID_WIDTH 4'h9
`define TBD_DEF_HZRD_ENTRIES 7'h40
`define TBD_DEF_SLOTRAM_TYPE 2'h2
`define TBD_DEF_CACHERAM_TYPE 2'h1
`define TBD_NUM_REGS         7
`define TBD_ADDR_W           16
`define TBD_ZERO32           32'h0000_0000
`endif

// ==== tbd_field.v ====
// one read-only discovery field, zero-extended to a bus word
`default_nettype none
module tbd_field #(
  parameter integer WIDTH = 1,
  parameter [WIDTH-1:0] VALUE = {WIDTH{1'b0}}
) (
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  output reg  [31:0] word_o
);
  // reloaded from the build value every cycle, so no write path can corrupt it
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      word_o <= {{(32-WIDTH){1'b0}}, VALUE};
    end else begin
      word_o <= {{(32-WIDTH){1'b0}}, VALUE};
    end
  end
endmodule // tbd_field
`default_nettype wire

// ==== tbd_discovery_regs.v ====
// apb slave holding the build-configuration discovery registers
`default_nettype none
`include "tbd_map.vh"
module tbd_discovery_regs #(
  parameter [`TBD_W_DIRECT_IDX-1:0]    DIRECT_INDEX_PARAM        = `TBD_DEF_DIRECT_IDX,
  parameter [`TBD_W_TLB_PARTS-1:0]     TLB_PARTITIONS_PARAM      = `TBD_DEF_TLB_PARTS,
  parameter [`TBD_W_OG_WIDTH-1:0]      OUTSTANDING_GROUP_WIDTH_PARAM = `TBD_DEF_OG_WIDTH,
  parameter [`TBD_W_PARTID_WIDTH-1:0]  PARTITION_ID_WIDTH_PARAM  = `TBD_DEF_PARTID_WIDTH,
  parameter [`TBD_W_HZRD_ENTRIES-1:0]  HAZARD_ENTRIES_PARAM      = `TBD_DEF_HZRD_ENTRIES,
  parameter [`TBD_W_SLOTRAM_TYPE-1:0]  SLOT_RAM_TYPE_PARAM       = `TBD_DEF_SLOTRAM_TYPE,
  parameter [`TBD_W_CACHERAM_TYPE-1:0] CACHE_RAM_TYPE_PARAM      = `TBD_DEF_CACHERAM_TYPE
) (
  input  wire                   sys_clk_i,
  input  wire                   reset_n_i,
  input  wire                   psel_i,
  input  wire                   penable_i,
  input  wire                   pwrite_i,
  input  wire [`TBD_ADDR_W-1:0] paddr_i,
  input  wire [31:0]            pwdata_i,
  output reg  [31:0]            prdata_o,
  output reg                    pready_o,
  output reg                    pslverr_o
);
  ////////////////////////////////////////////////////////////////////////////
  wire [31:0] direct_index_discovery;
  wire [31:0] tlb_partition_discovery;
  wire [31:0] outstanding_group_width_discovery;
  wire [31:0] partition_id_width_discovery;
  wire [31:0] hazard_entries_discovery;
  wire [31:0] slot_ram_type_discovery;
  wire [31:0] cache_ram_type_discovery;

  // entry 0: direct indexing flag
  tbd_field #(
    .WIDTH (`TBD_W_DIRECT_IDX),
    .VALUE (DIRECT_INDEX_PARAM)
  ) u_direct (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (direct_index_discovery)
  );

  // entry 1: tlb partition count
  tbd_field #(
    .WIDTH (`TBD_W_TLB_PARTS),
    .VALUE (TLB_PARTITIONS_PARAM)
  ) u_parts (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (tlb_partition_discovery)
  );

  // entry 2: outstanding-group width
  tbd_field #(
    .WIDTH (`TBD_W_OG_WIDTH),
    .VALUE (OUTSTANDING_GROUP_WIDTH_PARAM)
  ) u_og (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (outstanding_group_width_discovery)
  );

  // entry 3: partition id width
  tbd_field #(
    .WIDTH (`TBD_W_PARTID_WIDTH),
    .VALUE (PARTITION_ID_WIDTH_PARAM)
  ) u_partid (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (partition_id_width_discovery)
  );

  // entry 4: hazard entry count
  tbd_field #(
    .WIDTH (`TBD_W_HZRD_ENTRIES),
    .VALUE (HAZARD_ENTRIES_PARAM)
  ) u_hzrd (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (hazard_entries_discovery)
  );

  // entry 5: slot ram type
  tbd_field #(
    .WIDTH (`TBD_W_SLOTRAM_TYPE),
    .VALUE (SLOT_RAM_TYPE_PARAM)
  ) u_slot (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (slot_ram_type_discovery)
  );

  // entry 6: cache ram type
  tbd_field #(
    .WIDTH (`TBD_W_CACHERAM_TYPE),
    .VALUE (CACHE_RAM_TYPE_PARAM)
  ) u_cache (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .word_o    (cache_ram_type_discovery)
  );

  ////////////////////////////////////////////////////////////////////////////
  // table sizes, offsets, masks and bus phases
  localparam integer NUM_REGS     = `TBD_NUM_REGS;
  localparam integer ADDR_W       = `TBD_ADDR_W;
  localparam [1:0]   ST_IDLE      = 2'h0;
  localparam [1:0]   ST_ACCESS_RD = 2'h1;
  localparam [1:0]   ST_ACCESS_WR = 2'h2;

  // offsets in entry order; entry 0 sits in the lowest bits
  localparam [ADDR_W*NUM_REGS-1:0] OFS_TABLE = {
    `TBD_OFS_CACHERAM_TYPE,
    `TBD_OFS_SLOTRAM_TYPE,
    `TBD_OFS_HZRD_ENTRIES,
    `TBD_OFS_PARTID_WIDTH,
    `TBD_OFS_OG_WIDTH,
    `TBD_OFS_TLB_PARTS,
    `TBD_OFS_DIRECT_IDX
  };

  // field masks keep reserved bits zero at the mux itself, whatever
  // a future field module might produce
  localparam [32*NUM_REGS-1:0] MASK_TABLE = {
    {{(32-`TBD_W_CACHERAM_TYPE){1'h0}}, {`TBD_W_CACHERAM_TYPE{1'h1}}},
    {{(32-`TBD_W_SLOTRAM_TYPE){1'h0}}, {`TBD_W_SLOTRAM_TYPE{1'h1}}},
    {{(32-`TBD_W_HZRD_ENTRIES){1'h0}}, {`TBD_W_HZRD_ENTRIES{1'h1}}},
    {{(32-`TBD_W_PARTID_WIDTH){1'h0}}, {`TBD_W_PARTID_WIDTH{1'h1}}},
    {{(32-`TBD_W_OG_WIDTH){1'h0}}, {`TBD_W_OG_WIDTH{1'h1}}},
    {{(32-`TBD_W_TLB_PARTS){1'h0}}, {`TBD_W_TLB_PARTS{1'h1}}},
    {{(32-`TBD_W_DIRECT_IDX){1'h0}}, {`TBD_W_DIRECT_IDX{1'h1}}}
  };

  ////////////////////////////////////////////////////////////////////////////
  // the bank as an array of words, one entry per register
  wire [31:0] disc_word [0:NUM_REGS-1];

  assign disc_word[0] = direct_index_discovery;
  assign disc_word[1] = tlb_partition_discovery;
  assign disc_word[2] = outstanding_group_width_discovery;
  assign disc_word[3] = partition_id_width_discovery;
  assign disc_word[4] = hazard_entries_discovery;
  assign disc_word[5] = slot_ram_type_discovery;
  assign disc_word[6] = cache_ram_type_discovery;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and and-or read mux, one slice per entry;
  // an unmapped offset hits no entry and reads zero without an error
  wire [NUM_REGS-1:0] reg_hit;
  wire [31:0]         or_chain [0:NUM_REGS];
  wire [31:0]         next_prdata;

  assign or_chain[0] = `TBD_ZERO32;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_entry
      wire [ADDR_W-1:0] entry_ofs;
      wire [31:0]       entry_mask;
      wire [31:0]       entry_word;
      assign entry_ofs     = OFS_TABLE[ADDR_W*g +: ADDR_W];
      assign entry_mask    = MASK_TABLE[32*g +: 32];
      assign entry_word    = disc_word[g] & entry_mask;
      assign reg_hit[g]    = (paddr_i == entry_ofs);
      assign or_chain[g+1] = or_chain[g] | (entry_word & {32{reg_hit[g]}});
    end
  endgenerate

  assign next_prdata = or_chain[NUM_REGS];

  ////////////////////////////////////////////////////////////////////////////
  // request qualifiers
  wire setup;
  wire rd_setup;
  wire wr_setup;

  assign setup    = psel_i && !penable_i;
  assign rd_setup = setup && !pwrite_i;
  assign wr_setup = setup && pwrite_i;

  ////////////////////////////////////////////////////////////////////////////
  // bus phase: every setup is answered in the cycle after it, so a
  // back-to-back setup goes straight into another access phase
  reg [1:0] phase;
  reg [1:0] next_phase;

  always @* begin
    case (phase)
      // no transfer in progress
      ST_IDLE: begin
        if (rd_setup) begin
          next_phase = ST_ACCESS_RD;
        end else if (wr_setup) begin
          next_phase = ST_ACCESS_WR;
        end else begin
          next_phase = ST_IDLE;
        end
      end
      // answering a read
      ST_ACCESS_RD: begin
        if (rd_setup) begin
          next_phase = ST_ACCESS_RD;
        end else if (wr_setup) begin
          next_phase = ST_ACCESS_WR;
        end else begin
          next_phase = ST_IDLE;
        end
      end
      // answering a write whose data is dropped
      ST_ACCESS_WR: begin
        if (rd_setup) begin
          next_phase = ST_ACCESS_RD;
        end else if (wr_setup) begin
          next_phase = ST_ACCESS_WR;
        end else begin
          next_phase = ST_IDLE;
        end
      end
      default: begin
        next_phase = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      phase <= ST_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of the bus outputs; pwdata_i is never stored, since every
  // register of the bank is read-only
  reg        next_pready;
  reg        next_pslverr;
  reg [31:0] next_rdata;

  always @* begin
    next_pready  = 1'h0;
    next_pslverr = 1'h0;
    next_rdata   = prdata_o;
    case (next_phase)
      ST_ACCESS_RD: begin
        next_pready = 1'h1;
        next_rdata  = next_prdata;
      end
      ST_ACCESS_WR: begin
        next_pready = 1'h1;
        next_rdata  = `TBD_ZERO32;
      end
      default: begin
        next_pready = 1'h0;
        next_rdata  = prdata_o;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  // pready stands for exactly one cycle, the access phase
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'h0;
    end else begin
      pready_o <= next_pready;
    end
  end

  // this bank has no error response at all
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pslverr_o <= 1'h0;
    end else begin
      pslverr_o <= next_pslverr;
    end
  end

  // read data holds until the next setup
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= `TBD_ZERO32;
    end else begin
      prdata_o <= next_rdata;
    end
  end
endmodule // tbd_discovery_regs

`default_nettype wire

// ==== tbd_props.sv ====
// checker of the discovery bank
`default_nettype none
module tbd_props (
  input wire logic sys_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] prdata_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  property rd(a, v); psel_i && !penable_i && !pwrite_i && paddr_i == a |=> prdata_o == v; endproperty
  chk_direct_idx: assert property (rd(16'h8E50, 32'h0000_0001)) else $error("8E50");
  chk_tlb_parts: assert property (rd(16'h8E54, 32'h0000_0010)) else $error("8E54");
  chk_group_width: assert property (rd(16'h8E58, 32'h0000_0020)) else $error("8E58");
  chk_partid_width: assert property (rd(16'h8E5C, 32'h0000_0009)) else $error("8E5C");
  chk_hazard_cnt: assert property (rd(16'h8E60, 32'h0000_0040)) else $error("8E60");
  chk_slot_ram: assert property (rd(16'h8E64, 32'h0000_0002)) else $error("8E64");
  chk_cache_ram: assert property (rd(16'h8E68, 32'h0000_0001)) else $error("8E68");
  chk_write_drop: assert property (psel_i && !penable_i && pwrite_i |=>
    pready_o && !pslverr_o && prdata_o == 32'h0000_0000) else $error("write");
  cover property (pready_o && !pwrite_i);
  cover property (pready_o && pwrite_i);
  cover property (pready_o ##2 pready_o);
endmodule // tbd_props
bind tbd_discovery_regs tbd_props tbd_props_inst (.sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
  .pready_o, .pslverr_o, .paddr_i, .prdata_o);
`default_nettype wire

// ==== tbd_discovery_regs_bench.sv ====
// bench of the bank
`default_nettype none
module tbd_discovery_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic        rdy;
  logic        slverr;
  logic        rd_err;
  logic [15:0] addr   = 16'h0000;
  logic [31:0] pwdata = 32'hFFFF_FFFF;
  logic [31:0] prdata;
  logic [31:0] rd_val;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          i;
  int          k;
  logic [51:0] rows [10] = '{52'h8_E500_0000_0001, 52'h8_E540_0000_0010, 52'h8_E580_0000_0020, 52'h8_E5C0_0000_0009,
    52'h8_E600_0000_0040, 52'h8_E640_0000_0002, 52'h8_E680_0000_0001, 52'h8_E541_0000_0000, 52'h8_E540_0000_0010,
    52'h8_E6C0_0000_0000};
  tbd_discovery_regs tbd_discovery_regs_inst (.sys_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(slverr));
  initial forever #20 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("%0d mismatches in %0d comparisons", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one transfer, called just after a rising edge; pready is looked at mid-cycle,
  // so the value seen is the one that the completing rising edge samples
  task automatic xfer(input logic [15:0] a, input logic w);
    {addr, pwr, psel, pen} <= {a, w, 2'b10};
    @(posedge clk);
    pen <= 1'b1;
    @(negedge clk);
    for (k = 0; k < 20 && rdy !== 1'b1; k++) begin
      @(negedge clk);
    end
    rd_val = prdata;
    rd_err = slverr;
    check("pready", 32'(rdy), 32'h0000_0001);
    if (k == 20) complete_run;
    @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i++) begin
      xfer(rows[i][51:36], rows[i][32]);
      check("prdata", rd_val, rows[i][31:0]);
      check("pslverr", 32'(rd_err), 32'h0000_0000);
    end
    $display("register table done");
    xfer(16'h8E54, 1'b0);
    {addr, pwr, psel, pen} <= {16'h8E54, 1'b0, 2'b10};
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("reset prdata", prdata, 32'h0000_0000);
    check("reset pready", 32'(rdy), 32'h0000_0000);
    @(posedge clk);
    {psel, pen} <= 2'b00;
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("release pready", 32'(rdy), 32'h0000_0000);
    check("release prdata", prdata, 32'h0000_0000);
    @(posedge clk);
    xfer(16'h8E50, 1'b0);
    check("direct after reset", rd_val, 32'h0000_0001);
    check("pslverr after reset", 32'(rd_err), 32'h0000_0000);
    $display("mid-run reset done");
    {psel, pen} <= 2'b00;
    complete_run;
  end
endmodule // tbd_discovery_regs_bench
`default_nettype wire
